// file: logic/rxcd_top.sv
// Design decisions made here: the register decode and the APB interface to the registers.
module rxcd_top
  import rxcd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire rxcd_byte_s  rx_in,
  output rxcd_cell_s       cell_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // locate the single flipped bit giving this syndrome; bit 6 flags a hit
  function automatic logic [6:0] find_bit(input logic [7:0] syn);
    logic [6:0]  r;
    logic [39:0] e;
    r = 7'h00;
    for (int i = 0; i < 40; i++) begin
      e = 40'h1 << i;
      if ((crc8(e[39:8]) ^ e[7:0]) == syn) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  // self-synchronising x^43+1 descrambler, msb first
  function automatic logic [50:0] descr(input logic [7:0] d, input logic [42:0] s);
    logic [42:0] st;
    logic [7:0]  o;
    st = s;
    o  = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ st[42];
      st   = {st[41:0], d[i]};
    end
    return {st, o};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rxcd_state_s s_q;
  rxcd_state_s s_d;
  rxcd_link_s  lk;
  logic [7:0]  ctl;
  logic [7:0]  syn;
  logic        hec_ok;
  logic [6:0]  fix;
  logic [39:0] w40;
  logic [31:0] hdr_c;
  logic        corr;
  logic        bad;
  logic        idle_cell;
  logic [50:0] dsc;
  logic [7:0]  pl_byte;
  logic        ev_valid;
  logic        ev_inv;
  logic        ev_err;
  logic        ev_miss;
  logic [2:0]  li;
  logic [31:0] rd;
  logic        map_ok;
  logic        wr;
  logic        lcd_live;

  always_comb begin
    s_d       = s_q;
    ctl       = 8'h00;
    syn       = 8'h00;
    hec_ok    = 1'b0;
    fix       = 7'h00;
    w40       = 40'h0;
    hdr_c     = 32'h0;
    corr      = 1'b0;
    bad       = 1'b0;
    idle_cell = 1'b0;
    dsc       = 51'h0;
    pl_byte   = 8'h00;
    ev_valid  = 1'b0;
    ev_inv    = 1'b0;
    ev_err    = 1'b0;
    ev_miss   = 1'b0;
    lcd_live  = 1'b0;
    s_d.out.valid  = 1'b0;
    s_d.out.hdr    = 1'b0;
    s_d.out.filler = 1'b0;

    // ----------------------------------------------------------------
    // apb read decode and write
    // ----------------------------------------------------------------
    li     = paddr[7:5];
    rd     = 32'h0;
    map_ok = 1'b1;
    lk     = s_q.lk[li];
    lcd_live = (lk.cd != CD_SYNC) && (lk.lcd_cnt >= s_q.lcd_thr);
    if (paddr[11:8] == LINK_PAGE) begin
      case (paddr[4:0])
        OFF_CTRL:    rd[7:0] = s_q.ctrl[li];
        OFF_PARAM:   rd[15:0] = s_q.param[li];
        OFF_STATE:   rd[3:0] = {lk.fs, lk.cd};
        OFF_IRQ:     rd[LCD_IRQ_BIT] = lcd_live;
        OFF_ID:      rd[7:0] = {1'b0, lcd_live, 1'b0, lk.lat_lid};
        OFF_OOF_CNT: rd[7:0] = lk.oof_cnt;
        OFF_BAD_CNT: rd[15:0] = lk.bad_cnt;
        default:     map_ok = 1'b0;
      endcase
    end else begin
      case (paddr)
        ADDR_CD_CFG:     rd[7:0] = {s_q.cd_delta, s_q.cd_alpha};
        ADDR_LCD_THR:    rd[15:0] = s_q.lcd_thr;
        ADDR_FD_CFG:     rd[11:0] = {s_q.fd_gamma, s_q.fd_beta, s_q.fd_alpha};
        ADDR_OOF_STAT: begin
          for (int i = 0; i < NUM_LINKS; i++) begin
            rd[i] = s_q.lk[i].oof;
          end
        end
        ADDR_OOF_CLR:    rd = 32'h0;
        ADDR_LABEL0,
        ADDR_LABEL0 + 12'h004,
        ADDR_LABEL0 + 12'h008,
        ADDR_LABEL0 + 12'h00C: rd[7:0] = s_q.label[paddr[3:2]];
        default:         map_ok = 1'b0;
      endcase
    end
    if (psel && !penable) begin
      s_d.prdata = map_ok ? rd : 32'h0;
      s_d.perr   = !map_ok;
    end
    wr = psel && penable && pwrite && !s_q.perr;
    if (wr) begin
      if (paddr[11:8] == LINK_PAGE) begin
        if (paddr[4:0] == OFF_CTRL) begin
          s_d.ctrl[li] = pwdata[7:0];
        end
        if (paddr[4:0] == OFF_PARAM) begin
          s_d.param[li] = pwdata[15:0];
        end
      end else begin
        case (paddr)
          ADDR_CD_CFG: begin
            s_d.cd_alpha = pwdata[3:0];
            s_d.cd_delta = pwdata[7:4];
          end
          ADDR_LCD_THR: s_d.lcd_thr = pwdata[15:0];
          ADDR_FD_CFG: begin
            s_d.fd_alpha = pwdata[3:0];
            s_d.fd_beta  = pwdata[7:4];
            s_d.fd_gamma = pwdata[11:8];
          end
          ADDR_OOF_STAT: begin
            for (int i = 0; i < NUM_LINKS; i++) begin
              s_d.lk[i].oof = s_q.lk[i].oof & pwdata[i];
            end
          end
          ADDR_OOF_CLR: begin
            for (int i = 0; i < NUM_LINKS; i++) begin
              if (pwdata[i]) begin
                s_d.lk[i].oof_cnt = 8'h00;
              end
            end
          end
          default: begin
            if (paddr[11:4] == ADDR_LABEL0[11:4]) begin
              s_d.label[paddr[3:2]] = pwdata[7:0];
            end
          end
        endcase
      end
    end

    // ----------------------------------------------------------------
    // ima mode entry: latch link parameters
    // ----------------------------------------------------------------
    for (int i = 0; i < NUM_LINKS; i++) begin
      if (s_q.ctrl[i][CTRL_IMA] && !s_q.lk[i].ima_prev) begin
        s_d.lk[i].lat_lid  = s_q.param[i][4:0];
        s_d.lk[i].lat_m    = s_q.param[i][15:8];
        s_d.lk[i].cell_cnt = 8'h00;
      end
      if (!s_q.ctrl[i][CTRL_IMA]) begin
        s_d.lk[i].fs = FS_HUNT;
      end
      s_d.lk[i].ima_prev = s_q.ctrl[i][CTRL_IMA];
    end

    // ----------------------------------------------------------------
    // per-byte cell processing
    // ----------------------------------------------------------------
    if (rx_in.valid) begin
      lk  = s_d.lk[rx_in.link];
      ctl = s_q.ctrl[rx_in.link];
      w40 = {lk.hdr, rx_in.data};
      syn = crc8(lk.hdr) ^ (ctl[CTRL_COSET_OFF] ? 8'h00 : HEC_COSET) ^ rx_in.data;
      hec_ok = (syn == 8'h00);
      s_d.out.link = rx_in.link;
      if (lk.cd == CD_HUNT) begin
        if (hec_ok) begin
          lk.cd     = CD_PRESYNC;
          lk.pos    = POS_LABEL;
          lk.cd_cnt = 4'h0;
        end else begin
          lk.hunt_bytes = (lk.hunt_bytes == POS_LAST) ? 6'h00 : lk.hunt_bytes + 6'h01;
          if (lk.hunt_bytes == 6'h00 && lk.lcd_cnt != 16'hFFFF) begin
            lk.lcd_cnt = lk.lcd_cnt + 16'h0001;
          end
        end
      end else begin
        if (lk.pos == POS_HEC && lk.cd == CD_PRESYNC) begin
          if (!hec_ok) begin
            lk.cd = CD_HUNT;
          end else if (lk.cd_cnt + 4'h1 >= s_q.cd_delta) begin
            lk.cd      = CD_SYNC;
            lk.cd_cnt  = 4'h0;
            lk.lcd_cnt = 16'h0000;
            lk.hec     = HEC_CORR;
          end else begin
            lk.cd_cnt = lk.cd_cnt + 4'h1;
          end
        end else if (lk.pos == POS_HEC) begin
          fix   = find_bit(syn);
          corr  = !hec_ok && lk.hec == HEC_CORR && ctl[CTRL_CORR] && fix[6];
          hdr_c = corr ? (w40[39:8] ^ 32'((40'h1 << fix[5:0]) >> 8)) : lk.hdr;
          bad   = !hec_ok && !corr;
          lk.hec = hec_ok ? HEC_CORR : HEC_DETECT;
          if (bad) begin
            lk.bad_cnt = lk.bad_cnt + 16'h0001;
          end
          if (hec_ok) begin
            lk.cd_cnt = 4'h0;
          end else if (lk.cd_cnt + 4'h1 >= s_q.cd_alpha) begin
            lk.cd     = CD_HUNT;
            lk.cd_cnt = 4'h0;
          end else begin
            lk.cd_cnt = lk.cd_cnt + 4'h1;
          end
          idle_cell = (hdr_c == IDLE_HDR) || (hdr_c[31:4] == 28'h0 && !hdr_c[0]);
          lk.fill = bad && ctl[CTRL_DROP_BAD] && ctl[CTRL_IMA];
          lk.drop = (bad && ctl[CTRL_DROP_BAD] && !ctl[CTRL_IMA])
                    || (!bad && ctl[CTRL_IDLE_DROP] && idle_cell);
          if (!lk.drop) begin
            s_d.out.valid  = 1'b1;
            s_d.out.hdr    = 1'b1;
            s_d.out.filler = lk.fill;
            s_d.out.data   = lk.fill ? ICP_HDR : hdr_c;
          end
          lk.icp_cand = 1'b0;
          if (ctl[CTRL_IMA]) begin
            if (hdr_c == ICP_HDR && bad) begin
              ev_err      = 1'b1;
              lk.cell_cnt = 8'h00;
            end else if (lk.cell_cnt >= lk.lat_m) begin
              ev_miss     = 1'b1;
              lk.cell_cnt = 8'h00;
            end else begin
              lk.cell_cnt = lk.cell_cnt + 8'h01;
            end
            lk.icp_cand = (hdr_c == ICP_HDR) && !bad;
          end
        end else if (lk.cd == CD_SYNC && lk.pos > POS_HEC) begin
          dsc     = descr(rx_in.data, lk.scr);
          lk.scr  = dsc[50:8];
          pl_byte = ctl[CTRL_DESCR] ? dsc[7:0] : rx_in.data;
          if (!lk.drop) begin
            s_d.out.valid  = 1'b1;
            s_d.out.filler = lk.fill;
            s_d.out.data   = {24'h0, lk.fill ? FILL_BYTE : pl_byte};
          end
          if (lk.pos == POS_LABEL) begin
            lk.label_ok = (pl_byte == s_q.label[ctl[CTRL_GRP_LSB +: 2]]);
          end
          if (lk.pos == POS_CELL_ID && lk.icp_cand && pl_byte[CID_ICP_BIT]) begin
            lk.cell_cnt = 8'h00;
            ev_valid    = lk.label_ok && (pl_byte[4:0] == lk.lat_lid);
            ev_inv      = !ev_valid;
          end
        end
        lk.pos = (lk.pos == POS_LAST) ? 6'h00 : lk.pos + 6'h01;
      end
      lk.hdr = w40[31:0];

      // ----------------------------------------------------------------
      // frame sync machine
      // ----------------------------------------------------------------
      if (ctl[CTRL_IMA]) begin
        case (lk.fs)
          FS_HUNT: begin
            if (ev_valid) begin
              lk.fs     = FS_PRESYNC;
              lk.fs_cnt = 4'h1;
            end
          end
          FS_PRESYNC: begin
            if (ev_err || ev_miss || ev_inv) begin
              lk.fs = FS_HUNT;
            end else if (ev_valid) begin
              if (lk.fs_cnt + 4'h1 >= s_q.fd_gamma) begin
                lk.fs      = FS_SYNC;
                lk.inv_cnt = 4'h0;
                lk.err_cnt = 4'h0;
              end else begin
                lk.fs_cnt = lk.fs_cnt + 4'h1;
              end
            end
          end
          FS_SYNC: begin
            if (ev_valid) begin
              lk.inv_cnt = 4'h0;
              lk.err_cnt = 4'h0;
            end
            if (ev_inv) begin
              lk.inv_cnt = lk.inv_cnt + 4'h1;
            end
            if (ev_err) begin
              lk.err_cnt = lk.err_cnt + 4'h1;
            end
            if (ev_miss || (ev_inv && lk.inv_cnt >= s_q.fd_alpha)
                || (ev_err && lk.err_cnt >= s_q.fd_beta)) begin
              lk.fs      = FS_HUNT;
              lk.oof     = 1'b1;
              lk.oof_cnt = lk.oof_cnt + 8'h01;
            end
          end
          default: lk.fs = FS_HUNT;
        endcase
      end
      s_d.lk[rx_in.link] = lk;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.cd_alpha <= CD_ALPHA_RST;
      s_q.cd_delta <= CD_DELTA_RST;
      s_q.lcd_thr  <= LCD_THR_RST;
      s_q.fd_alpha <= FD_ALPHA_RST;
      s_q.fd_beta  <= FD_BETA_RST;
      s_q.fd_gamma <= FD_GAMMA_RST;
      for (int i = 0; i < NUM_LINKS; i++) begin
        s_q.param[i] <= {FRAME_M_RST, 8'h00};
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata   = s_q.prdata;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && s_q.perr;
  assign cell_out = s_q.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_CD_HUNT_NOT_SYNC: assert property (
    s_q.lk[0].cd == CD_HUNT |=> s_q.lk[0].cd != CD_SYNC)
    else $error("delineation skipped presync");
  AST_PRESYNC_BAD: assert property (
    rx_in.valid && rx_in.link == 3'h0 && s_q.lk[0].cd == CD_PRESYNC
    && s_q.lk[0].pos == POS_HEC && !hec_ok |=> s_q.lk[0].cd == CD_HUNT)
    else $error("bad hec in presync did not return to hunt");
  AST_SYNC_ENTRY: assert property (
    $changed(s_q.lk[0].cd) && s_q.lk[0].cd == CD_SYNC |-> $past(s_q.lk[0].cd) == CD_PRESYNC)
    else $error("sync entered from wrong state");
  AST_STATE_READ: assert property (
    psel && !penable && paddr == {LINK_PAGE, 3'h0, OFF_STATE}
    |=> prdata[1:0] == $past(s_q.lk[0].cd) && prdata[3:2] == $past(s_q.lk[0].fs))
    else $error("state register mismatch");
  AST_HEC_DETECT: assert property (
    rx_in.valid && rx_in.link == 3'h0 && s_q.lk[0].cd == CD_SYNC
    && s_q.lk[0].pos == POS_HEC && !hec_ok |=> s_q.lk[0].hec == HEC_DETECT)
    else $error("hec checker not in detection after error");
  AST_OUT_IN_SYNC: assert property (
    rx_in.valid && s_q.lk[rx_in.link].cd != CD_SYNC |=> !cell_out.valid)
    else $error("cell forwarded outside sync");
  AST_IDLE_DROP: assert property (
    rx_in.valid && rx_in.link == 3'h0 && s_q.lk[0].cd == CD_SYNC && s_q.lk[0].pos == POS_HEC
    && hec_ok && s_q.lk[0].hdr == IDLE_HDR && s_q.ctrl[0][CTRL_IDLE_DROP] |=> !cell_out.valid)
    else $error("idle cell not dropped");
  AST_FILLER_IMA: assert property (
    cell_out.valid && cell_out.filler |-> $past(s_q.ctrl[rx_in.link][CTRL_IMA])
    || s_q.ctrl[cell_out.link][CTRL_IMA])
    else $error("filler substituted outside ima mode");
  AST_FS_SYNC_ENTRY: assert property (
    $changed(s_q.lk[0].fs) && s_q.lk[0].fs == FS_SYNC |-> $past(s_q.lk[0].fs) == FS_PRESYNC)
    else $error("frame sync entered from wrong state");
  AST_OOF_LATCH: assert property (
    s_q.lk[0].fs == FS_SYNC ##1 s_q.lk[0].fs == FS_HUNT && s_q.ctrl[0][CTRL_IMA] |-> s_q.lk[0].oof)
    else $error("out of frame flag not latched");

endmodule

// file: shared/rxcd_pkg.sv
package rxcd_pkg;
  // ----------------------------------------------------------------
  // sizes and cell layout
  // ----------------------------------------------------------------
  localparam int         NUM_LINKS   = 8;
  localparam int         NUM_GROUPS  = 4;
  localparam logic [5:0] POS_HEC     = 6'h04;
  localparam logic [5:0] POS_LABEL   = 6'h05;
  localparam logic [5:0] POS_CELL_ID = 6'h06;
  localparam logic [5:0] POS_LAST    = 6'h34;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam logic [7:0] HEC_COSET   = 8'h55;
  localparam logic [31:0] IDLE_HDR   = 32'h00000001;
  localparam logic [31:0] ICP_HDR    = 32'h0000000B;
  localparam logic [7:0] FILL_BYTE   = 8'h6A;
  localparam int         CID_ICP_BIT = 7;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CD_CFG   = 12'h000;
  localparam logic [11:0] ADDR_LCD_THR  = 12'h004;
  localparam logic [11:0] ADDR_FD_CFG   = 12'h008;
  localparam logic [11:0] ADDR_OOF_STAT = 12'h00C;
  localparam logic [11:0] ADDR_OOF_CLR  = 12'h010;
  localparam logic [11:0] ADDR_LABEL0   = 12'h020;
  localparam logic [3:0]  LINK_PAGE     = 4'h1;
  localparam logic [4:0]  OFF_CTRL      = 5'h00;
  localparam logic [4:0]  OFF_PARAM     = 5'h04;
  localparam logic [4:0]  OFF_STATE     = 5'h08;
  localparam logic [4:0]  OFF_IRQ       = 5'h0C;
  localparam logic [4:0]  OFF_ID        = 5'h10;
  localparam logic [4:0]  OFF_OOF_CNT   = 5'h14;
  localparam logic [4:0]  OFF_BAD_CNT   = 5'h18;

  // link control and status bits
  localparam int CTRL_IMA       = 0;
  localparam int CTRL_COSET_OFF = 1;
  localparam int CTRL_CORR      = 2;
  localparam int CTRL_DROP_BAD  = 3;
  localparam int CTRL_IDLE_DROP = 4;
  localparam int CTRL_DESCR     = 5;
  localparam int CTRL_GRP_LSB   = 6;
  localparam int LCD_IRQ_BIT    = 1;
  localparam int LCD_ID_BIT     = 6;

  // reset values
  localparam logic [3:0]  CD_ALPHA_RST = 4'h7;
  localparam logic [3:0]  CD_DELTA_RST = 4'h6;
  localparam logic [15:0] LCD_THR_RST  = 16'h0168;
  localparam logic [3:0]  FD_ALPHA_RST = 4'h2;
  localparam logic [3:0]  FD_BETA_RST  = 4'h2;
  localparam logic [3:0]  FD_GAMMA_RST = 4'h1;
  localparam logic [7:0]  FRAME_M_RST  = 8'h80;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CD_HUNT = 2'b00, CD_PRESYNC = 2'b01, CD_SYNC = 2'b10} rxcd_cd_e;
  typedef enum logic [1:0] {FS_HUNT = 2'b00, FS_PRESYNC = 2'b01, FS_SYNC = 2'b10} rxcd_fs_e;
  typedef enum logic {HEC_CORR = 1'b0, HEC_DETECT = 1'b1} rxcd_hec_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] link;
    logic [7:0] data;
  } rxcd_byte_s;

  typedef struct packed {
    logic        valid;
    logic [2:0]  link;
    logic        hdr;
    logic        filler;
    logic [31:0] data;
  } rxcd_cell_s;

  typedef struct packed {
    rxcd_cd_e    cd;
    logic [5:0]  pos;
    logic [31:0] hdr;
    logic [3:0]  cd_cnt;
    logic [5:0]  hunt_bytes;
    logic [15:0] lcd_cnt;
    rxcd_hec_e   hec;
    logic [42:0] scr;
    logic        drop;
    logic        fill;
    logic [15:0] bad_cnt;
    rxcd_fs_e    fs;
    logic [3:0]  fs_cnt;
    logic [3:0]  inv_cnt;
    logic [3:0]  err_cnt;
    logic [7:0]  cell_cnt;
    logic        icp_cand;
    logic        label_ok;
    logic        oof;
    logic [7:0]  oof_cnt;
    logic        ima_prev;
    logic [4:0]  lat_lid;
    logic [7:0]  lat_m;
  } rxcd_link_s;

  typedef struct packed {
    rxcd_link_s [NUM_LINKS-1:0]        lk;
    logic [NUM_LINKS-1:0][7:0]         ctrl;
    logic [NUM_LINKS-1:0][15:0]        param;
    logic [NUM_GROUPS-1:0][7:0]        label;
    logic [3:0]                        cd_alpha;
    logic [3:0]                        cd_delta;
    logic [15:0]                       lcd_thr;
    logic [3:0]                        fd_alpha;
    logic [3:0]                        fd_beta;
    logic [3:0]                        fd_gamma;
    logic [31:0]                       prdata;
    logic                              perr;
    rxcd_cell_s                        out;
  } rxcd_state_s;
endpackage

// file: verification/rxcd_framer.sv
module rxcd_framer
  import rxcd_pkg::*;
(
  input  wire logic core_clk,
  output rxcd_byte_s rx_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial rx_out = '0;

  function automatic logic [7:0] crc8(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ h[i]) == 1'b1) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  task automatic put(input logic [2:0] lk, input logic [7:0] b);
    @(posedge core_clk);
    rx_out <= '{valid: 1'b1, link: lk, data: b};
  endtask

  // released line shows inverted data
  task automatic idle();
    @(posedge core_clk);
    rx_out <= '{valid: 1'b0, link: rx_out.link, data: ~rx_out.data};
  endtask

  task automatic send_cell(input logic [2:0] lk, input logic [31:0] h, input logic [7:0] err, input logic coset);
    logic [7:0] hec;
    hec = crc8(h) ^ (coset ? HEC_COSET : 8'h00) ^ err;
    for (int i = 3; i >= 0; i--) put(lk, h[8*i +: 8]);
    put(lk, hec);
    for (int i = 0; i < 48; i++) put(lk, 8'h00);
    idle();
  endtask
endmodule

// file: verification/tb.sv
module tb;
  import rxcd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] HDR_A = 32'h00A0B0C0;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, last_hdr;
  rxcd_byte_s  rx_in;
  rxcd_cell_s  cell_out;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          hdr_beats = 0;

  rxcd_top u_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .cell_out(cell_out));
  rxcd_framer u_framer (.core_clk(core_clk), .rx_out(rx_in));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cell_out.valid === 1'b1 && cell_out.hdr === 1'b1) begin
      hdr_beats++;
      last_hdr = cell_out.data;
    end
    if (cycles == 30000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    chk(what, exp, rd_q);
  endtask

  function automatic logic [11:0] lreg(input int l, input logic [4:0] off);
    return 12'h100 + 12'(l * 32) + {7'h00, off};
  endfunction

  task automatic cells(input int lk, input int n, input logic [31:0] h, input logic [7:0] err);
    repeat (n) u_framer.send_cell(3'(lk), h, err, 1'b1);
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    int b;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ADDR_CD_CFG, 32'h00000067, "cd cfg");
    rd(ADDR_LCD_THR, 32'h00000168, "loss thr");
    rd(12'h0FC, 32'h00000000, "unmapped");
    chk("unmapped err", 32'h00000001, {31'h0, err_q});
    rd(lreg(0, OFF_STATE), 32'h00000000, "state reset");
    repeat (7) u_framer.put(3'd0, 8'h00);
    cells(0, 1, HDR_A, 8'h00);
    rd(lreg(0, OFF_STATE), 32'h00000001, "lock");
    cells(0, 5, HDR_A, 8'h00);
    rd(lreg(0, OFF_STATE), 32'h00000001, "delta less one");
    cells(0, 1, HDR_A, 8'h00);
    rd(lreg(0, OFF_STATE), 32'h00000002, "sync");
    b = hdr_beats;
    cells(0, 1, HDR_A, 8'h00);
    chk("hdr beats", 32'(b + 1), 32'(hdr_beats));
    chk("hdr data", HDR_A, last_hdr);
    apb(1'b1, lreg(0, OFF_CTRL), 32'h00000018);
    b = hdr_beats;
    u_framer.send_cell(3'd0, IDLE_HDR, 8'h00, 1'b1);
    cells(0, 6, HDR_A, 8'hFF);
    chk("dropped beats", 32'(b), 32'(hdr_beats));
    rd(lreg(0, OFF_STATE), 32'h00000002, "alpha less one");
    cells(0, 1, HDR_A, 8'hFF);
    rd(lreg(0, OFF_STATE), 32'h00000000, "alpha hunt");
    cells(0, 1, HDR_A, 8'h00);
    cells(0, 1, HDR_A, 8'hFF);
    rd(lreg(0, OFF_STATE), 32'h00000000, "presync bad");
    apb(1'b1, lreg(1, OFF_CTRL), 32'h00000002);
    u_framer.send_cell(3'd1, HDR_A, 8'h00, 1'b0);
    rd(lreg(1, OFF_STATE), 32'h00000001, "coset off");
    u_framer.send_cell(3'd2, HDR_A, 8'h00, 1'b0);
    rd(lreg(2, OFF_STATE), 32'h00000000, "coset on");
    apb(1'b1, ADDR_LCD_THR, 32'h00000002);
    repeat (110) u_framer.put(3'd3, 8'h00);
    rd(lreg(3, OFF_IRQ), 32'h00000002, "loss status");
    rd(lreg(3, OFF_ID), 32'h00000040, "loss id");
    cells(3, 7, HDR_A, 8'h00);
    rd(lreg(3, OFF_IRQ), 32'h00000000, "loss cleared");
    apb(1'b1, lreg(3, OFF_CTRL), 32'h00000004);
    b = hdr_beats;
    cells(3, 1, HDR_A, 8'h01);
    chk("corr beats", 32'(b + 1), 32'(hdr_beats));
    chk("corr hdr", HDR_A, last_hdr);
    rd(lreg(3, OFF_BAD_CNT), 32'h00000000, "corr not counted");
    rd(lreg(0, OFF_BAD_CNT), 32'h00000007, "bad count");
    end_sim();
  end
endmodule
